//--- include/atlm_pkg.sv
/*
  Types shared by the axis travel limit monitor files.
  Assumes compilation before any design module.
*/
package atlm_pkg;

  // Operating mode reported by the motion controller
  typedef enum logic [1:0] {
    ATLM_MODE_OTHER = 2'h0,
    ATLM_MODE_PROFILE_POS = 2'h1,
    ATLM_MODE_JOG = 2'h2,
    ATLM_MODE_HOMING = 2'h3
  } atlm_mode_t;

  // Switch evaluation codes
  typedef enum logic [1:0] {
    ATLM_POL_INACTIVE = 2'h0,
    ATLM_POL_NC = 2'h1,
    ATLM_POL_NO = 2'h2
  } atlm_pol_t;

  // Stop sequencer states, one-hot
  typedef enum logic [1:0] {
    ATLM_ST_RUN = 2'b01,
    ATLM_ST_HOLD = 2'b10
  } atlm_state_t;

endpackage

//--- include/atlm_regs.svh
/*
  Register offsets, field positions, reset values and range constants of the
  axis travel limit monitor.
  Assumes it is included by bare name from the design files; definitions only.
*/
`ifndef ATLM_REGS_SVH
`define ATLM_REGS_SVH

// Parameter addresses on the parameter access port
`define ATLM_ADDR_SOFT_LIM_EN     16'h0606
`define ATLM_ADDR_SOFT_LIM_POS    16'h0608
`define ATLM_ADDR_SOFT_LIM_NEG    16'h060a
`define ATLM_ADDR_HOME_POL        16'h061c
`define ATLM_ADDR_NEG_POL         16'h061e
`define ATLM_ADDR_POS_POL         16'h0620
`define ATLM_ADDR_LATCHED_STATUS  16'h0700
`define ATLM_ADDR_AXIS_STATUS     16'h0702
`define ATLM_ADDR_REF_POSITION    16'h1e18
`define ATLM_ADDR_ACT_POSITION    16'h1e1a

// Reset values
`define ATLM_RST_SOFT_LIM_EN      16'h0000
`define ATLM_RST_SOFT_LIM_POS     32'h7fffffff
`define ATLM_RST_SOFT_LIM_NEG     32'h80000000
`define ATLM_RST_HOME_POL         16'h0001
`define ATLM_RST_NEG_POL          16'h0001
`define ATLM_RST_POS_POL          16'h0001

// Largest legal field values
`define ATLM_SOFT_LIM_EN_MAX      16'h0003
`define ATLM_LIM_POL_MAX          16'h0002

// Soft limit enable field bits
`define ATLM_EN_POS_BIT           0
`define ATLM_EN_NEG_BIT           1

// Latched signal status bit positions
`define ATLM_LAT_HW_POS_BIT       1
`define ATLM_LAT_SOFT_LIM_BIT     2
`define ATLM_LAT_HW_NEG_BIT       3
`define ATLM_LAT_OVERTRAVEL_BIT   4

// Axis status bit positions
`define ATLM_AX_REF_OK_BIT        0
`define ATLM_AX_STOP_BIT          1
`define ATLM_AX_POS_HIT_BIT       2
`define ATLM_AX_NEG_HIT_BIT       3
`define ATLM_AX_HOME_HIT_BIT      4

// Absolute positioning range with default scaling
`define ATLM_POS_RANGE_MIN        32'shc0000000
`define ATLM_POS_RANGE_MAX        32'sh3fffffff

`endif

//--- src/atlm_monitor.sv
/*
  Axis travel limit monitor: positioning range, reference point validity,
  software end-of-travel limits and hardware limit / home switch evaluation,
  with a parameter access port for configuration and readback.
  Assumes all inputs are synchronous to clock and that the motion controller
  honours stop_request and move_reject and applies pos_set_zero.
*/
// Overview of operation
// - Absolute positions are bounded to -1073741824 .. 1073741823 user units.
// - Passing a positioning limit is allowed except in absolute profile moves.
// - Passing a positioning limit clears the homing-valid flag.
// - A relative profile move that would pass a limit zeroes position at start.
// - Soft limits act only while homing-valid is set, relative to the zero point.
// - A soft limit trip sets bit 2 of the latched signal status.
// - Soft limits compare the reference position, not the actual position.
// - Soft limit enable: 0 none, 1 positive, 2 negative, 3 both; resets to 0.
// - Soft limits default to the int32 extremes; writes outside the user range become USER_MAX.
// - Enabled hardware limit hits during motion stop the motor and are flagged.
// - Limit evaluation: 0 ignore, 1 normally closed, 2 normally open; reset 1.
// - Home switch evaluation accepts 1 or 2, resets to 1, acts only when homing.
// - Jog motion leaving a limit switch region is permitted.
// - The current motor position is readable in user units.
`timescale 1ns/100ps
`include "atlm_regs.svh"

module atlm_monitor #(
  parameter logic signed [31:0] USER_MIN = 32'sh80000000,
  parameter logic signed [31:0] USER_MAX = 32'sh7fffffff
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [15:0] param_addr,
  input wire logic param_wr,
  input wire logic param_rd,
  input wire logic [31:0] param_wdata,
  output logic [31:0] param_rdata,
  output logic param_ack,
  output logic param_err,
  input wire logic positive_end_switch_input,
  input wire logic negative_end_switch_input,
  input wire logic home_switch_input,
  input wire atlm_pkg::atlm_mode_t op_mode,
  input wire logic moving,
  input wire logic dir_positive,
  input wire logic homing_done,
  input wire logic move_start,
  input wire logic move_relative,
  input wire logic signed [31:0] move_target,
  input wire logic signed [31:0] ref_position,
  input wire logic signed [31:0] act_position,
  output logic stop_request,
  output logic move_reject,
  output logic pos_set_zero,
  output logic ref_ok,
  output logic home_switch_hit
);

  // Elaboration check: the clamp window must be ordered
  if (USER_MIN > USER_MAX) begin : g_bad_range
    $error("atlm_monitor: USER_MIN above USER_MAX");
  end

  // Replace a written limit outside the permissible user range by USER_MAX
  function automatic logic [31:0] clamp_user(input logic signed [31:0] v);
    logic [31:0] r;
    r = v;
    if (v > USER_MAX || v < USER_MIN) begin
      r = USER_MAX;
    end
    return r;
  endfunction

  // True when a position lies outside the absolute positioning range
  function automatic logic out_of_range(input logic signed [32:0] v);
    logic o;
    o = (v > 33'(`ATLM_POS_RANGE_MAX)) || (v < 33'(`ATLM_POS_RANGE_MIN));
    return o;
  endfunction

  logic [15:0] soft_limit_enable_q, soft_limit_enable_d;
  logic [31:0] soft_limit_positive_q, soft_limit_positive_d;
  logic [31:0] soft_limit_negative_q, soft_limit_negative_d;
  logic [15:0] home_switch_polarity_q, home_switch_polarity_d;
  logic [15:0] neg_switch_polarity_q, neg_switch_polarity_d;
  logic [15:0] pos_switch_polarity_q, pos_switch_polarity_d;
  logic [15:0] latched_signal_status_q, latched_signal_status_d;
  logic ref_ok_q, ref_ok_d;
  logic abs_move_q, abs_move_d;
  logic move_reject_q, move_reject_d;
  logic pos_set_zero_q, pos_set_zero_d;
  logic home_hit_q, home_hit_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic err_q, err_d;
  atlm_pkg::atlm_state_t state_q, state_d;
  logic wr_bad;
  logic pos_hit, neg_hit, home_hit;
  logic soft_limit_pos_on, soft_limit_neg_on;
  logic hw_stop, soft_stop, abs_stop, overtravel;
  logic jog_away_pos, jog_away_neg;
  logic start_pp, rel_predict_over;
  logic signed [32:0] predicted;
  logic [15:0] axis_status;

  // Switch evaluation; limits always evaluated, home only while homing
  atlm_switch_eval u_pos_eval (
    .raw(positive_end_switch_input),
    .polarity(pos_switch_polarity_q),
    .gate(1'b1),
    .hit(pos_hit)
  );
  atlm_switch_eval u_neg_eval (
    .raw(negative_end_switch_input),
    .polarity(neg_switch_polarity_q),
    .gate(1'b1),
    .hit(neg_hit)
  );
  atlm_switch_eval u_home_eval (
    .raw(home_switch_input),
    .polarity(home_switch_polarity_q),
    .gate(op_mode == atlm_pkg::ATLM_MODE_HOMING),
    .hit(home_hit)
  );

  // Limit conditions; reference position is the controller setpoint, so the
  // motor itself may come to rest short of the limit
  always_comb begin
    soft_limit_pos_on = soft_limit_enable_q[`ATLM_EN_POS_BIT];
    soft_limit_neg_on = soft_limit_enable_q[`ATLM_EN_NEG_BIT];
    soft_stop = moving && ref_ok_q &&
                ((soft_limit_pos_on && dir_positive &&
                  ref_position >= $signed(soft_limit_positive_q)) ||
                 (soft_limit_neg_on && !dir_positive &&
                  ref_position <= $signed(soft_limit_negative_q)));
    jog_away_pos = (op_mode == atlm_pkg::ATLM_MODE_JOG) && !dir_positive;
    jog_away_neg = (op_mode == atlm_pkg::ATLM_MODE_JOG) && dir_positive;
    hw_stop = moving && ((pos_hit && !jog_away_pos) ||
                         (neg_hit && !jog_away_neg));
    // Only absolute profile moves are held inside the range
    abs_stop = moving && abs_move_q &&
               ((dir_positive && ref_position >= `ATLM_POS_RANGE_MAX) ||
                (!dir_positive && ref_position <= `ATLM_POS_RANGE_MIN));
    overtravel = out_of_range(33'(ref_position));
    start_pp = move_start && (op_mode == atlm_pkg::ATLM_MODE_PROFILE_POS);
    predicted = 33'(act_position) + 33'(move_target);
    rel_predict_over = start_pp && move_relative && out_of_range(predicted);
  end

  // Parameter writes: illegal codes are refused and the old value kept
  always_comb begin
    soft_limit_enable_d = soft_limit_enable_q;
    soft_limit_positive_d = soft_limit_positive_q;
    soft_limit_negative_d = soft_limit_negative_q;
    home_switch_polarity_d = home_switch_polarity_q;
    neg_switch_polarity_d = neg_switch_polarity_q;
    pos_switch_polarity_d = pos_switch_polarity_q;
    wr_bad = 1'b0;
    if (param_wr) begin
      unique case (param_addr)
        `ATLM_ADDR_SOFT_LIM_EN: begin
          if (param_wdata[15:0] <= `ATLM_SOFT_LIM_EN_MAX && param_wdata[31:16] == 16'h0000) begin
            soft_limit_enable_d = param_wdata[15:0];
          end else begin
            wr_bad = 1'b1;
          end
        end
        `ATLM_ADDR_SOFT_LIM_POS: soft_limit_positive_d = clamp_user(param_wdata);
        `ATLM_ADDR_SOFT_LIM_NEG: soft_limit_negative_d = clamp_user(param_wdata);
        `ATLM_ADDR_HOME_POL: begin
          if (param_wdata == 32'(atlm_pkg::ATLM_POL_NC) ||
              param_wdata == 32'(atlm_pkg::ATLM_POL_NO)) begin
            home_switch_polarity_d = param_wdata[15:0];
          end else begin
            wr_bad = 1'b1;
          end
        end
        `ATLM_ADDR_NEG_POL: begin
          if (param_wdata <= 32'(`ATLM_LIM_POL_MAX)) begin
            neg_switch_polarity_d = param_wdata[15:0];
          end else begin
            wr_bad = 1'b1;
          end
        end
        `ATLM_ADDR_POS_POL: begin
          if (param_wdata <= 32'(`ATLM_LIM_POL_MAX)) begin
            pos_switch_polarity_d = param_wdata[15:0];
          end else begin
            wr_bad = 1'b1;
          end
        end
        `ATLM_ADDR_LATCHED_STATUS: wr_bad = 1'b0;
        default: wr_bad = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      soft_limit_enable_q <= `ATLM_RST_SOFT_LIM_EN;
      soft_limit_positive_q <= `ATLM_RST_SOFT_LIM_POS;
      soft_limit_negative_q <= `ATLM_RST_SOFT_LIM_NEG;
      home_switch_polarity_q <= `ATLM_RST_HOME_POL;
      neg_switch_polarity_q <= `ATLM_RST_NEG_POL;
      pos_switch_polarity_q <= `ATLM_RST_POS_POL;
    end else begin
      soft_limit_enable_q <= soft_limit_enable_d;
      soft_limit_positive_q <= soft_limit_positive_d;
      soft_limit_negative_q <= soft_limit_negative_d;
      home_switch_polarity_q <= home_switch_polarity_d;
      neg_switch_polarity_q <= neg_switch_polarity_d;
      pos_switch_polarity_q <= pos_switch_polarity_d;
    end
  end

  // Reference validity, latched events and move-start actions.
  // Events set sticky bits; a clear write in the same cycle loses to the set.
  always_comb begin
    ref_ok_d = ref_ok_q;
    if (overtravel || rel_predict_over) begin
      ref_ok_d = 1'b0;
    end
    if (homing_done) begin
      ref_ok_d = 1'b1;
    end
    latched_signal_status_d = latched_signal_status_q;
    if (param_wr && param_addr == `ATLM_ADDR_LATCHED_STATUS) begin
      latched_signal_status_d = latched_signal_status_q & ~param_wdata[15:0];
    end
    if (soft_stop) begin
      latched_signal_status_d[`ATLM_LAT_SOFT_LIM_BIT] = 1'b1;
    end
    if (moving && pos_hit) begin
      latched_signal_status_d[`ATLM_LAT_HW_POS_BIT] = 1'b1;
    end
    if (moving && neg_hit) begin
      latched_signal_status_d[`ATLM_LAT_HW_NEG_BIT] = 1'b1;
    end
    if (overtravel && ref_ok_q) begin
      latched_signal_status_d[`ATLM_LAT_OVERTRAVEL_BIT] = 1'b1;
    end
    abs_move_d = abs_move_q;
    if (move_start) begin
      abs_move_d = start_pp && !move_relative;
    end
    move_reject_d = start_pp && !move_relative &&
                    out_of_range(33'(move_target));
    pos_set_zero_d = rel_predict_over;
    home_hit_d = home_hit;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ref_ok_q <= 1'b0;
      latched_signal_status_q <= 16'h0000;
      abs_move_q <= 1'b0;
      move_reject_q <= 1'b0;
      pos_set_zero_q <= 1'b0;
      home_hit_q <= 1'b0;
    end else begin
      ref_ok_q <= ref_ok_d;
      latched_signal_status_q <= latched_signal_status_d;
      abs_move_q <= abs_move_d;
      move_reject_q <= move_reject_d;
      pos_set_zero_q <= pos_set_zero_d;
      home_hit_q <= home_hit_d;
    end
  end

  // Stop sequencer: hold the stop until the axis is at rest and no cause
  // remains, so a chattering switch cannot release a half-stopped move
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      atlm_pkg::ATLM_ST_RUN: begin
        if (hw_stop || soft_stop || abs_stop) begin
          state_d = atlm_pkg::ATLM_ST_HOLD;
        end
      end
      atlm_pkg::ATLM_ST_HOLD: begin
        if (!moving && !hw_stop && !soft_stop && !abs_stop) begin
          state_d = atlm_pkg::ATLM_ST_RUN;
        end
      end
      default: state_d = atlm_pkg::ATLM_ST_HOLD;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= atlm_pkg::ATLM_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Readback: answer registered one cycle after the strobe
  always_comb begin
    axis_status = 16'h0000;
    axis_status[`ATLM_AX_REF_OK_BIT] = ref_ok_q;
    axis_status[`ATLM_AX_STOP_BIT] = (state_q == atlm_pkg::ATLM_ST_HOLD);
    axis_status[`ATLM_AX_POS_HIT_BIT] = pos_hit;
    axis_status[`ATLM_AX_NEG_HIT_BIT] = neg_hit;
    axis_status[`ATLM_AX_HOME_HIT_BIT] = home_hit_q;
    rdata_d = rdata_q;
    ack_d = param_rd || param_wr;
    err_d = param_wr && wr_bad;
    if (param_rd) begin
      unique case (param_addr)
        `ATLM_ADDR_SOFT_LIM_EN: rdata_d = {16'h0000, soft_limit_enable_q};
        `ATLM_ADDR_SOFT_LIM_POS: rdata_d = soft_limit_positive_q;
        `ATLM_ADDR_SOFT_LIM_NEG: rdata_d = soft_limit_negative_q;
        `ATLM_ADDR_HOME_POL: rdata_d = {16'h0000, home_switch_polarity_q};
        `ATLM_ADDR_NEG_POL: rdata_d = {16'h0000, neg_switch_polarity_q};
        `ATLM_ADDR_POS_POL: rdata_d = {16'h0000, pos_switch_polarity_q};
        `ATLM_ADDR_LATCHED_STATUS: rdata_d = {16'h0000, latched_signal_status_q};
        `ATLM_ADDR_AXIS_STATUS: rdata_d = {16'h0000, axis_status};
        `ATLM_ADDR_REF_POSITION: rdata_d = ref_position;
        `ATLM_ADDR_ACT_POSITION: rdata_d = act_position;
        default: begin
          rdata_d = 32'h00000000;
          err_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h00000000;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      err_q <= err_d;
    end
  end

  assign param_rdata = rdata_q;
  assign param_ack = ack_q;
  assign param_err = err_q;
  assign stop_request = (state_q == atlm_pkg::ATLM_ST_HOLD);
  assign move_reject = move_reject_q;
  assign pos_set_zero = pos_set_zero_q;
  assign ref_ok = ref_ok_q;
  assign home_switch_hit = home_hit_q;

endmodule

//--- src/atlm_switch_eval.sv
/*
  Evaluates one external switch input against its configured polarity code.
  Assumes the raw input is already synchronous to the block clock.
*/
`timescale 1ns/100ps

module atlm_switch_eval (
  input wire logic raw,
  input wire logic [15:0] polarity,
  input wire logic gate,
  output logic hit
);

  // Normally closed reads a broken wire as a hit, which is why it is failsafe
  always_comb begin
    hit = 1'b0;
    if (gate) begin
      if (polarity == 16'(atlm_pkg::ATLM_POL_NC)) begin
        hit = ~raw;
      end else if (polarity == 16'(atlm_pkg::ATLM_POL_NO)) begin
        hit = raw;
      end
    end
  end

endmodule

//--- testbench/atlm_props.sv
/*
  Concurrent checks on the ports of the axis travel limit monitor.
  Assumes binding into atlm_monitor; reset is asynchronous and active high.
*/
`timescale 1ns/100ps

module atlm_props (
  input wire logic clock,
  input wire logic reset,
  input wire logic param_wr,
  input wire logic param_rd,
  input wire logic [31:0] param_rdata,
  input wire logic param_ack,
  input wire logic param_err,
  input wire atlm_pkg::atlm_mode_t op_mode,
  input wire logic moving,
  input wire logic homing_done,
  input wire logic move_start,
  input wire logic move_relative,
  input wire logic signed [31:0] move_target,
  input wire logic signed [31:0] ref_position,
  input wire logic signed [31:0] act_position,
  input wire logic stop_request,
  input wire logic move_reject,
  input wire logic pos_set_zero,
  input wire logic ref_ok,
  input wire logic home_switch_hit
);
  localparam logic signed [32:0] POS_LO = 33'sh1c0000000;
  localparam logic signed [32:0] POS_HI = 33'sh03fffffff;
  // Wide sums, so a 32-bit wrap cannot hide a range crossing
  wire logic signed [32:0] rel_sum = 33'(act_position) + 33'(move_target);
  wire logic signed [32:0] tgt = 33'(move_target);
  wire logic signed [32:0] refp = 33'(ref_position);
  wire logic pp_start = move_start && (op_mode == atlm_pkg::ATLM_MODE_PROFILE_POS);

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_ack_follows_strobe: assert property ((param_wr || param_rd) |=> param_ack)
    else $error("parameter access not acknowledged");
  a_ack_needs_strobe: assert property (!(param_wr || param_rd) |=>
    !param_ack && !param_err)
    else $error("acknowledge without access");
  a_rdata_holds: assert property (!param_rd |=> $stable(param_rdata))
    else $error("read data moved without a read");
  a_abs_reject: assert property (pp_start && !move_relative &&
    (tgt > POS_HI || tgt < POS_LO) |=> move_reject)
    else $error("absolute move past range not refused");
  a_abs_accept: assert property (pp_start && !move_relative &&
    tgt <= POS_HI && tgt >= POS_LO |=> !move_reject)
    else $error("absolute move inside range refused");
  a_rel_zero: assert property (pp_start && move_relative &&
    (rel_sum > POS_HI || rel_sum < POS_LO) |=> pos_set_zero)
    else $error("relative overrun did not zero position");
  a_rel_ref_lost: assert property (pp_start && move_relative && !homing_done &&
    (rel_sum > POS_HI || rel_sum < POS_LO) |=> !ref_ok) else $error("reference kept on overrun");
  a_overtravel_ref: assert property ((refp > POS_HI || refp < POS_LO) && !homing_done
    |=> !ref_ok) else $error("reference kept past positioning limit");
  a_homing_sets: assert property (homing_done |=> ref_ok)
    else $error("homing did not validate reference");
  a_home_gated: assert property (op_mode != atlm_pkg::ATLM_MODE_HOMING |=>
    !home_switch_hit)
    else $error("home switch evaluated outside homing");
  a_stop_needs_move: assert property ($rose(stop_request) |-> $past(moving))
    else $error("stop raised at standstill");
endmodule

bind atlm_monitor atlm_props u_props (
  .clock, .reset, .param_wr, .param_rd, .param_rdata, .param_ack, .param_err, .op_mode,
  .moving, .homing_done, .move_start, .move_relative, .move_target, .ref_position,
  .act_position, .stop_request, .move_reject, .pos_set_zero, .ref_ok, .home_switch_hit
);

//--- testbench/atlm_switch_model.sv
/*
  Behavioural model of one external end or home switch and its wiring.
  Assumes the bench says whether the axis sits on the switch and how it is wired.
*/
`timescale 1ns/100ps

module atlm_switch_model (
  input wire logic on_switch,
  input wire logic wired_no,
  output logic raw
);
  // Closed contacts open on a hit, so a broken wire also reads as a hit
  always_comb begin
    raw = wired_no ? on_switch : !on_switch;
  end
endmodule

//--- testbench/testbench.sv
/*
  Self-checking bench for the axis travel limit monitor: parameter port tasks,
  motion level drivers and switch models. Assumes the design sits alone at top.
*/
`timescale 1ns/100ps
`include "atlm_regs.svh"

module testbench;
  logic clock, reset, param_wr, param_rd, param_ack, param_err;
  logic [15:0] param_addr;
  logic [31:0] param_wdata, param_rdata;
  logic pos_raw, neg_raw, home_raw, pos_on, neg_on, home_on, pos_no, neg_no, home_no;
  atlm_pkg::atlm_mode_t op_mode;
  logic moving, dir_positive, homing_done, move_start, move_relative;
  logic signed [31:0] move_target, ref_position, act_position;
  logic stop_request, move_reject, pos_set_zero, ref_ok, home_switch_hit;
  int err_total = 0;
  int n_compared = 0;
  logic [15:0] reg_addr [6];
  logic [31:0] reg_rst [6];
  logic [15:0] bad_addr [6];
  logic [31:0] bad_data [6];

  atlm_monitor uut (.clock, .reset, .param_addr, .param_wr, .param_rd, .param_wdata,
    .param_rdata, .param_ack, .param_err, .positive_end_switch_input(pos_raw),
    .negative_end_switch_input(neg_raw), .home_switch_input(home_raw), .op_mode, .moving,
    .dir_positive, .homing_done, .move_start, .move_relative, .move_target, .ref_position,
    .act_position, .stop_request, .move_reject, .pos_set_zero, .ref_ok, .home_switch_hit);
  atlm_switch_model u_pos_sw (.on_switch(pos_on), .wired_no(pos_no), .raw(pos_raw));
  atlm_switch_model u_neg_sw (.on_switch(neg_on), .wired_no(neg_no), .raw(neg_raw));
  atlm_switch_model u_home_sw (.on_switch(home_on), .wired_no(home_no), .raw(home_raw));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Step past the edge so registered outputs have settled before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One strobe; the answer stands for a single cycle, so it is looked at there
  task automatic acc(input logic wr, input logic [15:0] addr, input logic [31:0] data,
                     input logic exp_err);
    @(posedge clock);
    param_addr <= addr;
    param_wdata <= data;
    param_wr <= wr;
    param_rd <= !wr;
    @(posedge clock);
    param_wr <= 1'b0;
    param_rd <= 1'b0;
    #1;
    chk_bit(param_ack, 1'b1);
    chk_bit(param_err, exp_err);
  endtask

  task automatic rd_reg(input logic [15:0] addr, input logic [31:0] exp, input logic exp_err);
    acc(1'b0, addr, 32'h0, exp_err);
    chk_word(param_rdata, exp);
  endtask

  task automatic chk_regs;
    for (int i = 0; i < 6; i++) begin
      rd_reg(reg_addr[i], reg_rst[i], 1'b0);
    end
  endtask

  // Motion levels and switch contact, then two edges for the registered answer
  task automatic drive(input atlm_pkg::atlm_mode_t m, input logic mov, input logic dir,
                       input logic [31:0] refp, input logic ph, input logic nh, input logic hh);
    @(posedge clock);
    op_mode <= m;
    moving <= mov;
    dir_positive <= dir;
    ref_position <= refp;
    pos_on <= ph;
    neg_on <= nh;
    home_on <= hh;
    cyc(2);
  endtask

  task automatic start(input logic rel, input logic [31:0] tgt, input logic [31:0] act,
                       input logic exp_rej, input logic exp_zero);
    @(posedge clock);
    move_start <= 1'b1;
    move_relative <= rel;
    move_target <= tgt;
    act_position <= act;
    @(posedge clock);
    move_start <= 1'b0;
    #1;
    chk_bit(move_reject, exp_rej);
    chk_bit(pos_set_zero, exp_zero);
  endtask

  task automatic home_pulse;
    @(posedge clock);
    homing_done <= 1'b1;
    @(posedge clock);
    homing_done <= 1'b0;
    #1;
    chk_bit(ref_ok, 1'b1);
  endtask

  // Hang guard: 100000 cycles of 50 ns
  initial begin
    #5000000;
    err_total++;
    conclude();
  end

  initial begin
    reset = 1'b1;
    {param_wr, param_rd, param_addr, param_wdata} = '0;
    {pos_on, neg_on, home_on, pos_no, neg_no, home_no} = '0;
    {moving, dir_positive, homing_done, move_start, move_relative} = '0;
    op_mode = atlm_pkg::ATLM_MODE_OTHER;
    move_target = 32'h0;
    ref_position = 32'h0;
    act_position = 32'h1388;
    reg_addr = '{`ATLM_ADDR_SOFT_LIM_EN, `ATLM_ADDR_SOFT_LIM_POS, `ATLM_ADDR_SOFT_LIM_NEG,
                 `ATLM_ADDR_HOME_POL, `ATLM_ADDR_NEG_POL, `ATLM_ADDR_POS_POL};
    reg_rst = '{32'h0, 32'h7fffffff, 32'h80000000, 32'h1, 32'h1, 32'h1};
    bad_addr = '{16'h0606, 16'h0606, 16'h061e, 16'h0620, 16'h061c, 16'h061c};
    bad_data = '{32'h4, 32'h10001, 32'h3, 32'h3, 32'h0, 32'h3};
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    chk_regs();
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, bad_addr[i], bad_data[i], 1'b1);
    end
    chk_regs();
    rd_reg(16'h0610, 32'h0, 1'b1);
    rd_reg(`ATLM_ADDR_ACT_POSITION, 32'h1388, 1'b0);
    acc(1'b1, `ATLM_ADDR_SOFT_LIM_POS, 32'h3e8, 1'b0);
    acc(1'b1, `ATLM_ADDR_SOFT_LIM_NEG, 32'hfffffc18, 1'b0);
    rd_reg(`ATLM_ADDR_SOFT_LIM_NEG, 32'hfffffc18, 1'b0);
    home_pulse();
    // Actual position sits beyond the positive limit all along; only the setpoint may trip
    for (int e = 0; e < 4; e++) begin
      acc(1'b1, `ATLM_ADDR_SOFT_LIM_EN, 32'(e), 1'b0);
      acc(1'b1, `ATLM_ADDR_LATCHED_STATUS, 32'hffff, 1'b0);
      drive(atlm_pkg::ATLM_MODE_OTHER, 1'b1, 1'b1, 32'h3e8, 1'b0, 1'b0, 1'b0);
      chk_bit(stop_request, e[0]);
      rd_reg(`ATLM_ADDR_LATCHED_STATUS, {29'h0, e[0], 2'h0}, 1'b0);
      drive(atlm_pkg::ATLM_MODE_OTHER, 1'b0, 1'b1, 32'h0, 1'b0, 1'b0, 1'b0);
      chk_bit(stop_request, 1'b0);
      drive(atlm_pkg::ATLM_MODE_OTHER, 1'b1, 1'b0, 32'hfffffc18, 1'b0, 1'b0, 1'b0);
      chk_bit(stop_request, e[1]);
      drive(atlm_pkg::ATLM_MODE_OTHER, 1'b0, 1'b0, 32'h0, 1'b0, 1'b0, 1'b0);
    end
    drive(atlm_pkg::ATLM_MODE_OTHER, 1'b0, 1'b1, 32'h40000000, 1'b0, 1'b0, 1'b0);
    chk_bit(ref_ok, 1'b0);
    drive(atlm_pkg::ATLM_MODE_OTHER, 1'b1, 1'b1, 32'h3e8, 1'b0, 1'b0, 1'b0);
    chk_bit(stop_request, 1'b0);
    drive(atlm_pkg::ATLM_MODE_OTHER, 1'b0, 1'b1, 32'h0, 1'b0, 1'b0, 1'b0);
    acc(1'b1, `ATLM_ADDR_SOFT_LIM_EN, 32'h0, 1'b0);
    for (int p = 0; p < 3; p++) begin
      acc(1'b1, `ATLM_ADDR_POS_POL, 32'(p), 1'b0);
      acc(1'b1, `ATLM_ADDR_NEG_POL, 32'(p), 1'b0);
      @(posedge clock);
      {pos_no, neg_no} <= {2{p == 2}};
      drive(atlm_pkg::ATLM_MODE_OTHER, 1'b1, 1'b1, 32'h0, 1'b1, 1'b0, 1'b0);
      chk_bit(stop_request, p != 0);
      drive(atlm_pkg::ATLM_MODE_OTHER, 1'b0, 1'b1, 32'h0, 1'b0, 1'b0, 1'b0);
      drive(atlm_pkg::ATLM_MODE_OTHER, 1'b1, 1'b0, 32'h0, 1'b0, 1'b1, 1'b0);
      chk_bit(stop_request, p != 0);
      drive(atlm_pkg::ATLM_MODE_OTHER, 1'b0, 1'b0, 32'h0, 1'b0, 1'b0, 1'b0);
      chk_bit(stop_request, 1'b0);
    end
    drive(atlm_pkg::ATLM_MODE_JOG, 1'b1, 1'b0, 32'h0, 1'b1, 1'b0, 1'b0);
    chk_bit(stop_request, 1'b0);
    drive(atlm_pkg::ATLM_MODE_JOG, 1'b1, 1'b1, 32'h0, 1'b1, 1'b0, 1'b0);
    chk_bit(stop_request, 1'b1);
    rd_reg(`ATLM_ADDR_AXIS_STATUS, 32'h6, 1'b0);
    drive(atlm_pkg::ATLM_MODE_OTHER, 1'b0, 1'b1, 32'h0, 1'b0, 1'b0, 1'b0);
    acc(1'b1, `ATLM_ADDR_HOME_POL, 32'h2, 1'b0);
    @(posedge clock);
    home_no <= 1'b1;
    drive(atlm_pkg::ATLM_MODE_HOMING, 1'b0, 1'b1, 32'h0, 1'b0, 1'b0, 1'b1);
    chk_bit(home_switch_hit, 1'b1);
    drive(atlm_pkg::ATLM_MODE_OTHER, 1'b0, 1'b1, 32'h0, 1'b0, 1'b0, 1'b1);
    chk_bit(home_switch_hit, 1'b0);
    drive(atlm_pkg::ATLM_MODE_PROFILE_POS, 1'b0, 1'b1, 32'h0, 1'b0, 1'b0, 1'b0);
    start(1'b0, 32'h40000000, 32'h1388, 1'b1, 1'b0);
    start(1'b0, 32'h3fffffff, 32'h1388, 1'b0, 1'b0);
    start(1'b0, 32'hbfffffff, 32'h1388, 1'b1, 1'b0);
    home_pulse();
    start(1'b1, 32'h337, 32'h3ffffcc8, 1'b0, 1'b0);
    chk_bit(ref_ok, 1'b1);
    start(1'b1, 32'h3e8, 32'h3ffffcc8, 1'b0, 1'b1);
    chk_bit(ref_ok, 1'b0);
    conclude();
  end
endmodule
